/* hdl/rpmc_defines.vh */
// Constants for the reset and power-mode controller
`ifndef RPMC_DEFINES_VH
`define RPMC_DEFINES_VH

// Register addresses
`define RPMC_ADDR_INT_EN0      8'h30
`define RPMC_ADDR_INT_EN1      8'h31
`define RPMC_ADDR_STAT1_RO     8'h41
`define RPMC_ADDR_STAT1_SC     8'h44
`define RPMC_ADDR_OSC_CTL      8'h50
`define RPMC_ADDR_CLK_SEL      8'h51
`define RPMC_ADDR_MISC_CTL     8'h52
`define RPMC_ADDR_MODE         8'h53

// Reset values
`define RPMC_RST_INT_EN0       8'hF7
`define RPMC_RST_INT_EN1       8'hFF
`define RPMC_RST_STAT1         8'h04
`define RPMC_RST_OSC_CTL       8'h06
`define RPMC_RST_CLK_SEL       8'h00
`define RPMC_RST_MISC_CTL      8'h00

// Field positions
`define RPMC_BIT_RST_DONE      4
`define RPMC_BIT_TMR_B         3
`define RPMC_BIT_TMR_A         2
`define RPMC_BIT_CLK_OVR       2
`define RPMC_EN1_RD_ONES       8'hE3
`define RPMC_EN0_RD_ONES       8'hC6

// Sequence values
`define RPMC_OSC_SYNC          8'h07
`define RPMC_OSC_PIN_CTL       8'h03
`define RPMC_OSC_KEEP_ON       8'h06
`define RPMC_CLK_SEL_RTC       8'h05
`define RPMC_CLK_SEL_INT_DIV1  8'h00

// Power mode codes
`define RPMC_MODE_NORMAL       3'h0
`define RPMC_MODE_RAM_PRES     3'h1
`define RPMC_MODE_ULP_LCD      3'h2
`define RPMC_MODE_ULP_RTC      3'h3
`define RPMC_MODE_SHUTDOWN     3'h4

// Timing: clock period and times in ns, counts derived
`define RPMC_CLK_NS            8
`define RPMC_RST_PULSE_NS      1000
`define RPMC_STARTUP_NS        20000
`define RPMC_POR_DELAY_NS      10000000
`define RPMC_RST_PULSE_CYC     ((`RPMC_RST_PULSE_NS + `RPMC_CLK_NS - 1) / `RPMC_CLK_NS)
`define RPMC_STARTUP_CYC       (`RPMC_STARTUP_NS / `RPMC_CLK_NS)
`define RPMC_POR_DELAY_CYC     (`RPMC_POR_DELAY_NS / `RPMC_CLK_NS)

`endif

/* hdl/rpmc_ctrl.v */
// Reset sequencer, interrupt enable/status and RAM preservation clock control
// Summary of operation
// RULE_01: Enable bit 4 gates reset-complete interrupt
// RULE_02: Enable bit 3 gates timer B overflow
// RULE_03: Enable bit 2 gates timer A overflow
// RULE_04: Unused enable bits ignore writes, read one
// RULE_05: Reset state restores every register value
// RULE_06: GPIO high impedance with pull-up in reset
// RULE_07: Interrupt pin held high during reset
// RULE_08: Internal oscillator stopped while in reset
// RULE_09: After reset all enabled except oscillator-fail
// RULE_10: Reset only from power-on or pin
// RULE_11: Start oscillator, then assert interrupt pin
// RULE_12: Host waits, masks, then configures mode
// RULE_13: Power-on holds reset, then release delay
// RULE_14: Minimum pin pulse; startup delay after high
// RULE_15: Normal, RAM preservation, ULP, shutdown modes; code implements only normal and RAM preservation
// RULE_16: Host talks only in normal mode
// RULE_17: RAM preservation clocks from RTC oscillator
// RULE_18: Five-step entry sequence into RAM preservation
// RULE_19: Pin low forces internal oscillator undivided
// RULE_20: Writing 0x06 keeps oscillator enabled
// RULE_21: SPI hosts may tie pin to select
// RULE_22: Entry needs override clear, RTC running
// RULE_23: Self-clearing status at 0x44, bits 4-2
// RULE_24: Interrupt asserted when enabled flag pending
`timescale 1ns/1ps
`include "rpmc_defines.vh"

module rpmc_ctrl #(
   parameter POR_DELAY_CYC = `RPMC_POR_DELAY_CYC    // Power-on release delay in cycles
) (
   input  wire       clock,           // System clock, 125 MHz
   input  wire       rst,             // Synchronous reset, active high
   input  wire       supply_ok,       // Power-on detector, high above threshold
   input  wire       rst_pin_n,       // External reset pin, active low
   input  wire       clk_ctl_pin,     // Clock-control pin from host
   input  wire       rtc_osc_running, // RTC oscillator enabled and running
   input  wire       timer_a_ovf,     // Timer A overflow pulse
   input  wire       timer_b_ovf,     // Timer B overflow pulse
   input  wire [7:0] reg_addr,        // Register address
   input  wire [7:0] reg_wdata,       // Register write data
   input  wire       reg_wr,          // Register write strobe
   input  wire       reg_rd,          // Register read strobe
   output reg  [7:0] reg_rdata_q,     // Register read data
   output reg        int_n_q,         // Interrupt pin, active low
   output reg        gpio_hiz_q,      // GPIO forced to high impedance
   output reg        gpio_pullup_q,   // GPIO weak pull-up enable
   output reg        osc_enable_q,    // Internal oscillator enable
   output reg        sys_clk_rtc_q,   // System clock from RTC oscillator
   output reg  [2:0] power_mode_q,    // Current power mode code
   output reg        dev_ready_q      // Device out of reset and running
);

   // Sequencer states
   localparam [1:0] ST_RESET   = 2'd0;  // Held in reset
   localparam [1:0] ST_POR     = 2'd1;  // Power-on release delay
   localparam [1:0] ST_STARTUP = 2'd2;  // Oscillator starting
   localparam [1:0] ST_RUN     = 2'd3;  // Fully operational

   localparam integer POR_INT   = POR_DELAY_CYC;        // Release delay as integer
   localparam integer START_INT = `RPMC_STARTUP_CYC;    // Startup delay as integer
   localparam integer PULSE_INT = `RPMC_RST_PULSE_CYC;  // Minimum pulse as integer
   localparam [23:0]  POR_CYC   = POR_INT[23:0];        // Sized release delay
   localparam [23:0]  START_CYC = START_INT[23:0];      // Sized startup delay
   localparam [23:0]  PULSE_CYC = PULSE_INT[23:0];      // Sized minimum pulse
   localparam [7:0]   STAT_RST  = `RPMC_RST_STAT1;      // Status reset, full byte

   // Pin synchronisers, three stages each
   wire [2:0] pin_raw = {clk_ctl_pin, rst_pin_n, supply_ok};  // Raw pins
   reg  [2:0] sync1_q;                                        // First stage
   reg  [2:0] sync2_q;                                        // Second stage
   reg  [2:0] sync3_q;                                        // Third stage
   reg  [2:0] pin_q;                                          // Filtered levels

   // Sequencer state
   reg  [1:0]  state_q;        // Current state
   reg  [1:0]  state_d;        // Next state
   reg  [23:0] cnt_q;          // Delay counter
   reg  [23:0] cnt_d;          // Next counter
   reg  [23:0] low_cnt_q;      // Reset pin low duration
   reg         pin_reset_q;    // Qualified pin reset
   reg         por_seen_q;     // Supply was low, release via power-on path

   // Registers
   reg  [3:0] en0_q;           // Enable group zero stored bits 5,4,3,0
   reg  [2:0] en1_q;           // Enable group one bits 4:2
   reg  [2:0] stat_q;          // Status flags bits 4:2
   reg  [7:0] osc_ctl_q;       // Oscillator control
   reg  [7:0] clk_sel_q;       // Clock select
   reg  [7:0] misc_ctl_q;      // Misc control
   reg        ram_pres_q;      // In RAM preservation mode
   reg        clk_pin_prev_q;  // Previous filtered clock-control pin

   wire in_reset   = (state_q == ST_RESET);                       // Reset state
   wire reg_clear  = rst | in_reset;                              // Register reset term
   wire wr_en0     = reg_wr & (reg_addr == `RPMC_ADDR_INT_EN0);   // Write group zero
   wire wr_en1     = reg_wr & (reg_addr == `RPMC_ADDR_INT_EN1);   // Write group one
   wire wr_osc     = reg_wr & (reg_addr == `RPMC_ADDR_OSC_CTL);   // Write osc control
   wire wr_clk     = reg_wr & (reg_addr == `RPMC_ADDR_CLK_SEL);   // Write clock select
   wire wr_misc    = reg_wr & (reg_addr == `RPMC_ADDR_MISC_CTL);  // Write misc control
   wire rd_stat_sc = reg_rd & (reg_addr == `RPMC_ADDR_STAT1_SC);  // Clearing read
   wire clk_rise   = pin_q[2] & ~clk_pin_prev_q;                  // Pin went high
   wire clk_fall   = ~pin_q[2] & clk_pin_prev_q;                  // Pin went low
   wire [7:0] en1_rd = `RPMC_EN1_RD_ONES | {3'b000, en1_q, 2'b00};  // Group one view
   wire [7:0] en0_rd = `RPMC_EN0_RD_ONES
                       | {2'b00, en0_q[3], en0_q[2], en0_q[1], 2'b00, en0_q[0]};  // Group zero view
   wire [7:0] stat_rd = {3'b000, stat_q, 2'b00};                  // Status view
   wire       irq_any = |(stat_q & en1_q);                        // Enabled and pending
   wire       ram_entry_ok;                                        // Entry allowed

   // Three-stage synchroniser; level changes when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clock) begin
            if (rst) begin
               sync1_q[gi] <= 1'b1;
               sync2_q[gi] <= 1'b1;
               sync3_q[gi] <= 1'b1;
               pin_q[gi]   <= 1'b1;
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               // Glitch of one cycle is dropped
               if (sync2_q[gi] == sync3_q[gi]) begin
                  pin_q[gi] <= sync3_q[gi];
               end
            end
         end
      end
   endgenerate

   // Reset pin qualification: short pulses do not force reset
   always @(posedge clock) begin
      if (rst) begin
         low_cnt_q   <= 24'h000000;
         pin_reset_q <= 1'b0;
      end else if (pin_q[1]) begin
         low_cnt_q   <= 24'h000000;
         pin_reset_q <= 1'b0;
      // RULE_14: minimum pulse width
      end else if (low_cnt_q >= PULSE_CYC - 24'h000001) begin
         pin_reset_q <= 1'b1;
      end else begin
         low_cnt_q <= low_cnt_q + 24'h000001;
      end
   end

   // Next state of the reset sequencer
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_RESET: begin
            cnt_d = 24'h000000;
            // RULE_10: exit only when both sources quiet
            if (pin_q[0] & ~pin_reset_q) begin
               state_d = por_seen_q ? ST_POR : ST_STARTUP;
            end
         end
         ST_POR: begin
            // RULE_13: power-on release delay
            if (cnt_q >= POR_CYC - 24'h000001) begin
               state_d = ST_STARTUP;
               cnt_d   = 24'h000000;
            end else begin
               cnt_d = cnt_q + 24'h000001;
            end
         end
         ST_STARTUP: begin
            // RULE_14: startup delay after pin high
            if (cnt_q >= START_CYC - 24'h000001) begin
               state_d = ST_RUN;
               cnt_d   = 24'h000000;
            end else begin
               cnt_d = cnt_q + 24'h000001;
            end
         end
         ST_RUN: begin
            cnt_d = 24'h000000;
         end
         default: begin
            state_d = ST_RESET;
            cnt_d   = 24'h000000;
         end
      endcase
      // RULE_10: supply low or qualified pin reset
      if (~pin_q[0] | pin_reset_q) begin
         state_d = ST_RESET;
         cnt_d   = 24'h000000;
      end
   end

   // Sequencer registers
   always @(posedge clock) begin
      if (rst) begin
         state_q    <= ST_RESET;
         cnt_q      <= 24'h000000;
         por_seen_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         // RULE_13: supply dip selects power-on path
         if (~pin_q[0]) begin
            por_seen_q <= 1'b1;
         end else if (state_q == ST_POR) begin
            por_seen_q <= 1'b0;
         end
      end
   end

   // Interrupt enable registers
   always @(posedge clock) begin
      // RULE_05: reset state restores values
      if (reg_clear) begin
         // RULE_09: all on except oscillator-fail
         en0_q <= {1'b1, 1'b1, 1'b0, 1'b1};
         en1_q <= 3'b111;
      end else begin
         if (wr_en0) begin
            en0_q <= {reg_wdata[5], reg_wdata[4], reg_wdata[3], reg_wdata[0]};
         end
         // RULE_04: only bits 4:2 stored
         if (wr_en1) begin
            en1_q <= reg_wdata[4:2];
         end
      end
   end

   // Status flags; a new event beats a clearing read in the same cycle
   always @(posedge clock) begin
      if (reg_clear) begin
         stat_q <= STAT_RST[4:2];
      end else begin
         // RULE_23: read of 0x44 clears flags
         if (rd_stat_sc) begin
            stat_q <= 3'b000;
         end
         // RULE_11: ready flag on reaching run
         if (state_q == ST_STARTUP && state_d == ST_RUN) begin
            stat_q[2] <= 1'b1;
         end
         if (timer_b_ovf) begin
            stat_q[1] <= 1'b1;
         end
         if (timer_a_ovf) begin
            stat_q[0] <= 1'b1;
         end
      end
   end

   // RULE_22: override clear and RTC running
   assign ram_entry_ok = ~misc_ctl_q[`RPMC_BIT_CLK_OVR] & rtc_osc_running;

   // Clock control registers and RAM preservation mode
   always @(posedge clock) begin
      if (reg_clear) begin
         osc_ctl_q      <= `RPMC_RST_OSC_CTL;
         clk_sel_q      <= `RPMC_RST_CLK_SEL;
         misc_ctl_q     <= `RPMC_RST_MISC_CTL;
         ram_pres_q     <= 1'b0;
         clk_pin_prev_q <= pin_q[2];
      end else begin
         clk_pin_prev_q <= pin_q[2];
         if (wr_osc) begin
            osc_ctl_q <= reg_wdata;
         end
         if (wr_misc) begin
            misc_ctl_q <= reg_wdata;
         end
         if (ram_pres_q) begin
            // RULE_19: pin low returns to internal oscillator
            if (clk_fall) begin
               ram_pres_q <= 1'b0;
               clk_sel_q  <= `RPMC_CLK_SEL_INT_DIV1;
            end
         end else begin
            if (wr_clk) begin
               clk_sel_q <= reg_wdata;
            end
            // RULE_18: pin rising completes entry
            if (clk_rise && osc_ctl_q == `RPMC_OSC_PIN_CTL
                && clk_sel_q == `RPMC_CLK_SEL_RTC && ram_entry_ok) begin
               ram_pres_q <= 1'b1;
            end
         end
      end
   end

   // Pin and clock outputs
   always @(posedge clock) begin
      if (rst) begin
         int_n_q       <= 1'b1;
         gpio_hiz_q    <= 1'b1;
         gpio_pullup_q <= 1'b1;
         osc_enable_q  <= 1'b0;
         sys_clk_rtc_q <= 1'b0;
         power_mode_q  <= `RPMC_MODE_NORMAL;
         dev_ready_q   <= 1'b0;
      end else begin
         // RULE_06: GPIO released only when running
         // Same state term as ready, so both change together
         gpio_hiz_q    <= (state_q != ST_RUN);
         gpio_pullup_q <= (state_q != ST_RUN);
         // RULE_07: interrupt high outside run
         // RULE_24: asserted when enabled flag pending
         // RULE_01: reset-complete gated by enable
         // RULE_02: timer B gated by enable
         // RULE_03: timer A gated by enable
         int_n_q <= ~((state_q == ST_RUN) & irq_any);
         // RULE_08: oscillator stopped in reset and power-on wait
         // RULE_11: oscillator starts before interrupt
         // RULE_17: RAM preservation stops oscillator
         // RULE_20: keep-on value holds oscillator running
         osc_enable_q  <= (state_d == ST_STARTUP || state_d == ST_RUN)
                          && (~ram_pres_q || osc_ctl_q == `RPMC_OSC_KEEP_ON);
         sys_clk_rtc_q <= (state_q == ST_RUN) & ram_pres_q;
         // RULE_15: mode code reports current power mode
         power_mode_q  <= ram_pres_q ? `RPMC_MODE_RAM_PRES : `RPMC_MODE_NORMAL;
         dev_ready_q   <= (state_q == ST_RUN);
      end
   end

   // Read data register; unmapped addresses read zero
   // RULE_16: full-rate access in normal mode
   always @(posedge clock) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RPMC_ADDR_INT_EN0:  reg_rdata_q <= en0_rd;
            // RULE_04: unused bits read one
            `RPMC_ADDR_INT_EN1:  reg_rdata_q <= en1_rd;
            `RPMC_ADDR_STAT1_RO: reg_rdata_q <= stat_rd;
            `RPMC_ADDR_STAT1_SC: reg_rdata_q <= stat_rd;
            `RPMC_ADDR_OSC_CTL:  reg_rdata_q <= osc_ctl_q;
            `RPMC_ADDR_CLK_SEL:  reg_rdata_q <= clk_sel_q;
            `RPMC_ADDR_MISC_CTL: reg_rdata_q <= misc_ctl_q;
            `RPMC_ADDR_MODE:     reg_rdata_q <= {5'b00000, power_mode_q};
            default:             reg_rdata_q <= 8'h00;
         endcase
      end
   end

endmodule

/* dv/rpmc_checker.sv */
// Concurrent checks on the controller's ports
`timescale 1ns/1ps

module rpmc_checker #(
   parameter POR_DELAY_CYC = 20      // Power-on release delay
) (
   input wire       clock,           // System clock
   input wire       rst,             // Sync reset
   input wire       supply_ok,       // Supply good
   input wire       rst_pin_n,       // Reset pin
   input wire       clk_ctl_pin,     // Clock-control pin
   input wire       rtc_osc_running, // RTC running
   input wire       timer_a_ovf,     // Timer A event
   input wire       timer_b_ovf,     // Timer B event
   input wire [7:0] reg_addr,        // Address
   input wire [7:0] reg_wdata,       // Write data
   input wire       reg_wr,          // Write strobe
   input wire       reg_rd,          // Read strobe
   input wire [7:0] reg_rdata_q,     // Read data
   input wire       int_n_q,         // Interrupt, low
   input wire       gpio_hiz_q,      // GPIO hi-z
   input wire       gpio_pullup_q,   // GPIO pull-up
   input wire       osc_enable_q,    // Oscillator on
   input wire       sys_clk_rtc_q,   // RTC clocks system
   input wire [2:0] power_mode_q,    // Mode code
   input wire       dev_ready_q      // Running
);
   // One clock and one reset for every check
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   gpio_park_a: assert property (gpio_hiz_q == !dev_ready_q && gpio_pullup_q == !dev_ready_q)
      else $error("gpio park state wrong");
   int_idle_a: assert property (!dev_ready_q && !$past(dev_ready_q) |-> int_n_q)
      else $error("interrupt low outside run");
   osc_first_a: assert property ($rose(dev_ready_q) |-> $past(osc_enable_q, 8))
      else $error("run before oscillator start");
   osc_stop_a: assert property ($fell(dev_ready_q) |-> ##[0:3] !osc_enable_q)
      else $error("oscillator left on in reset");
   reset_cause_a: assert property ($fell(dev_ready_q) |-> !$past(rst_pin_n, 2) || !$past(supply_ok, 2))
      else $error("reset without a cause");
   en_ones_a: assert property (reg_rd && dev_ready_q && reg_addr == 8'h31 |=> (reg_rdata_q & 8'hE3) == 8'hE3)
      else $error("unused enable bits not one");
   en_back_a: assert property (
      reg_wr && dev_ready_q && reg_addr == 8'h31 ##2 reg_rd && reg_addr == 8'h31
      |=> reg_rdata_q == ($past(reg_wdata, 3) | 8'hE3)) else $error("enable readback wrong");
   mask_all_a: assert property (
      reg_wr && dev_ready_q && reg_addr == 8'h31 && reg_wdata[4:2] == 3'h0 ##1 !reg_wr |-> ##1 int_n_q)
      else $error("interrupt low with all masked");
   rtc_mode_a: assert property (power_mode_q == 3'h1 && $past(power_mode_q) == 3'h1 |-> sys_clk_rtc_q)
      else $error("preservation mode not on RTC clock");
   pin_wake_a: assert property (!clk_ctl_pin [*8] |-> power_mode_q == 3'h0 && !sys_clk_rtc_q)
      else $error("pin low did not restore clock");
endmodule

bind rpmc_ctrl rpmc_checker #(.POR_DELAY_CYC(POR_DELAY_CYC)) i_chk (.*);

/* dv/rpmc_host.sv */
// Host model for the controller's pins and register port
`timescale 1ns/1ps
`include "rpmc_defines.vh"

module rpmc_host (
   input  wire       clock,       // System clock
   input  wire [7:0] reg_rdata_q, // Read data
   output reg        rst_pin_n,   // Reset pin, low active
   output reg        clk_ctl_pin, // Clock-control pin
   output reg  [7:0] reg_addr,    // Address
   output reg  [7:0] reg_wdata,   // Write data
   output reg        reg_wr,      // Write strobe
   output reg        reg_rd       // Read strobe
);
   // Quiet bus, reset released
   initial begin
      rst_pin_n = 1'h1;
      clk_ctl_pin = 1'h0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
   end

   // traffic only in normal mode
   // Data inverted once taken so a late sample shows up
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clock);
      reg_wr = 1'h0;
      reg_wdata = ~d;
   endtask

   // Read data stands after the strobe edge
   task rd(input [7:0] a, output [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clock);
      reg_rd = 1'h0;
      @(negedge clock);
      d = reg_rdata_q;
   endtask

   // Pin change plus time for its synchroniser
   task pin(input v);
      @(negedge clock);
      clk_ctl_pin = v;
      repeat (10) @(negedge clock);
   endtask

   task reset_pin(input v);
      @(negedge clock);
      rst_pin_n = v;
   endtask

   task ram_enter;
      pin(1'h0);
      wr(`RPMC_ADDR_OSC_CTL, `RPMC_OSC_SYNC);
      wr(`RPMC_ADDR_OSC_CTL, `RPMC_OSC_PIN_CTL);
      wr(`RPMC_ADDR_CLK_SEL, `RPMC_CLK_SEL_RTC);
      pin(1'h1);
   endtask

   task ram_exit;
      pin(1'h0);
      wr(`RPMC_ADDR_OSC_CTL, `RPMC_OSC_KEEP_ON);
   endtask
endmodule

/* dv/rpmc_ctrl_bench.sv */
// Self-checking bench for the reset and power-mode controller
`timescale 1ns/1ps

module rpmc_ctrl_bench;
   reg        clock;                  // 125 MHz clock
   reg        rst;                    // Sync reset
   reg        supply_ok;              // Supply good
   reg        rtc_osc_running;        // RTC running
   reg        timer_a_ovf;            // Timer A event
   reg        timer_b_ovf;            // Timer B event
   wire       rst_pin_n, clk_ctl_pin, reg_wr, reg_rd;   // Host pins
   wire [7:0] reg_addr, reg_wdata, reg_rdata_q;         // Register port
   wire       int_n_q, gpio_hiz_q, gpio_pullup_q;       // Pin state
   wire       osc_enable_q, sys_clk_rtc_q, dev_ready_q; // Clock state
   wire [2:0] power_mode_q;           // Mode code
   reg  [7:0] rv;                     // Last read
   integer    miscompares = 0;        // Mismatches
   integer    num_checks = 0;         // Comparisons

   // Short power-on delay keeps the run brief
   rpmc_ctrl #(.POR_DELAY_CYC(20)) i_dut (.clock, .rst, .supply_ok, .rst_pin_n, .clk_ctl_pin,
      .rtc_osc_running, .timer_a_ovf, .timer_b_ovf, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .int_n_q, .gpio_hiz_q, .gpio_pullup_q, .osc_enable_q, .sys_clk_rtc_q,
      .power_mode_q, .dev_ready_q);
   rpmc_host i_host (.clock, .reg_rdata_q, .rst_pin_n, .clk_ctl_pin, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd);

   always #4 clock = ~clock;

   // Watchdog well beyond three boots
   initial begin
      #400000;
      miscompares = miscompares + 1;
      finish_test;
   end

   task chk(input string w, input [7:0] seen, input [7:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected %s: expected %h, seen %h", w, exp, seen);
      end
   endtask

   task rdc(input string w, input [7:0] a, input [7:0] e);
      i_host.rd(a, rv);
      chk(w, rv, e);
   endtask

   // Int, hi-z, pull-up, oscillator, ready
   task chk_parked;
      chk("park", {int_n_q, gpio_hiz_q, gpio_pullup_q, osc_enable_q, dev_ready_q}, 8'h1C);
   endtask

   // Bounded wait for reset-complete, with minimum delay
   task wait_up(input integer min);
      integer i;
      i = 0;
      while (int_n_q !== 1'h0 && i < 4000) begin
         @(negedge clock);
         i = i + 1;
      end
      chk("run", {int_n_q, osc_enable_q, dev_ready_q, gpio_hiz_q}, 8'h06);
      chk("delay", i >= min, 8'h01);
   endtask

   // after the wait, mask then configure
   task t_enables;
      integer b;
      rdc("en1", 8'h31, 8'hFF);
      rdc("en0", 8'h30, 8'hF7);
      rdc("stat", 8'h41, 8'h14);
      i_host.wr(8'h31, 8'h00);
      rdc("en1", 8'h31, 8'hE3);
      // One enable per pass; flags cleared after each pass
      for (b = 2; b <= 4; b = b + 1) begin
         i_host.wr(8'h31, 8'h01 << b);
         timer_a_ovf = (b != 3);
         timer_b_ovf = (b != 2);
         @(negedge clock);
         timer_a_ovf = 1'h0;
         timer_b_ovf = 1'h0;
         @(negedge clock);
         chk("int_n", int_n_q, {7'h00, b == 4});
         i_host.wr(8'h31, 8'h00);
         @(negedge clock);
         chk("int_n", int_n_q, 8'h01);
         rdc("stat", 8'h44, (b == 2) ? 8'h14 : ((b == 3) ? 8'h08 : 8'h0C));
      end
      rdc("stat", 8'h41, 8'h00);
      rdc("unmap", 8'h77, 8'h00);
      i_host.wr(8'h31, 8'hFF);
   endtask

   // Entry, exit and two refused entries
   task t_ram;
      i_host.ram_enter;
      chk("ram", {power_mode_q, sys_clk_rtc_q, osc_enable_q}, 8'h06);
      i_host.ram_exit;
      chk("norm", {power_mode_q, sys_clk_rtc_q, osc_enable_q}, 8'h01);
      rdc("clksel", 8'h51, 8'h00);
      rdc("oscctl", 8'h50, 8'h06);
      rdc("mode", 8'h53, 8'h00);
      i_host.wr(8'h52, 8'h04);
      i_host.ram_enter;
      chk("ovr", {power_mode_q, sys_clk_rtc_q}, 8'h00);
      i_host.wr(8'h52, 8'h00);
      rtc_osc_running = 1'h0;
      i_host.ram_enter;
      chk("rtcoff", {power_mode_q, sys_clk_rtc_q}, 8'h00);
      rtc_osc_running = 1'h1;
      i_host.pin(1'h0);
   endtask

   // Short pulse ignored, long pulse resets registers
   task t_pin;
      i_host.wr(8'h31, 8'h00);
      i_host.reset_pin(1'h0);
      repeat (50) @(negedge clock);
      i_host.reset_pin(1'h1);
      repeat (10) @(negedge clock);
      rdc("en1", 8'h31, 8'hE3);
      i_host.reset_pin(1'h0);
      repeat (200) @(negedge clock);
      chk_parked;
      i_host.reset_pin(1'h1);
      wait_up(2500);
      rdc("en1", 8'h31, 8'hFF);
   endtask

   // Supply dip takes the power-on path
   task t_supply;
      supply_ok = 1'h0;
      repeat (20) @(negedge clock);
      chk_parked;
      supply_ok = 1'h1;
      wait_up(2520);
      rdc("stat", 8'h41, 8'h14);
   endtask

   task finish_test;
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Reset 16 cycles, then every scenario
   initial begin
      clock = 1'h0;
      rst = 1'h1;
      supply_ok = 1'h1;
      rtc_osc_running = 1'h1;
      timer_a_ovf = 1'h0;
      timer_b_ovf = 1'h0;
      repeat (16) @(negedge clock);
      chk_parked;
      rst = 1'h0;
      wait_up(2520);
      t_enables;
      t_ram;
      t_pin;
      t_supply;
      finish_test;
   end
endmodule
